/* File: rtl/hpps_top.sv */
// module: hub port power, strap sampling and indicator led control
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R01: pull-up only while upstream supply present
// R02: power enable level follows polarity strap
// R03: loaded config drives leds active low
// R04: fixed-port straps sampled at reset release
// R05: strap 00: all removable, leds high
// R06: strap 01: port 1 fixed, led1 low
// R07: strap 10: ports fixed, led2 low
// R08: strap 11: ports fixed, leds low
// R09: during reset power pin from live strap
// R10: polarity latched at release, kept till reset
// R11: polarity 1 active high, 0 low
// R12: monitor flags over-current on sense input
// R13: select hi=1 lo=0 means strap config
// R14: system holds reset low one microsecond
// R15: over-current sense low, synchronised first
// R16: power stays off until software requests
module hpps_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic upstream_supply_sense,
  input wire logic overcurrent_sense_low,
  input wire logic power_polarity_strap,
  input wire logic config_select_lo,
  input wire logic config_select_hi,
  input wire logic [1:0] port_indicator_led_in,
  output logic [1:0] port_indicator_led_out,
  output logic [1:0] port_indicator_led_oe,
  output logic port_power_enable,
  output logic upstream_pullup_enable
);

  // synchroniser carrier
  hpps_sync_if sync_bus ();

  // phase and strap capture state
  hpps_pkg::hpps_state_t state;
  hpps_pkg::hpps_state_t next_state;
  logic [2:0] settle; // edges since release
  logic [2:0] next_settle;
  logic pol; // latched power polarity
  logic next_pol;
  logic [1:0] fixed; // latched fixed-port strap
  logic [1:0] next_fixed;
  logic [1:0] cfg; // latched config select {hi, lo}
  logic [1:0] next_cfg;

  // software registers and bus answer
  logic [hpps_pkg::CTRL_W-1:0] ctrl;
  logic [hpps_pkg::CTRL_W-1:0] next_ctrl;
  logic [hpps_pkg::EVT_W-1:0] evt;
  logic [hpps_pkg::EVT_W-1:0] next_evt;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // pin output flops
  logic ppe; // registered power enable after capture
  logic next_ppe;
  logic [1:0] next_led_out;
  logic [1:0] next_led_oe;
  logic next_pullup;

  // edge detection of synchronised levels
  logic oc_prev;
  logic sup_prev;

  // decoded helpers
  logic running; // straps taken, normal operation
  logic supply; // upstream supply present
  logic oc_active; // over-current reported
  logic internal_mode; // strap based configuration
  logic [1:0] nonrem; // non-removable ports {2, 1}
  logic [1:0] led_act_low; // per-port led polarity
  logic [1:0] led_on; // software led request
  logic led_enabled; // led pins driven at all
  logic power_on; // power request after gating
  logic bus_wr; // write completing this edge
  logic hit_ctrl;
  logic hit_stat;
  logic hit_evt;
  logic [hpps_pkg::EVT_W-1:0] evt_set;
  logic [hpps_pkg::EVT_W-1:0] evt_clr;
  logic [31:0] stat_word;

  // pins that cross into the clock domain
  assign sync_bus.raw[hpps_pkg::SB_SUPPLY] = upstream_supply_sense;
  assign sync_bus.raw[hpps_pkg::SB_OCL] = overcurrent_sense_low; // R15
  assign sync_bus.raw[hpps_pkg::SB_POL] = power_polarity_strap;
  assign sync_bus.raw[hpps_pkg::SB_FIX +: 2] = port_indicator_led_in;
  assign sync_bus.raw[hpps_pkg::SB_CFGLO] = config_select_lo;
  assign sync_bus.raw[hpps_pkg::SB_CFGHI] = config_select_hi;

  // three-flop synchroniser for every pin input
  hpps_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .bus(sync_bus)
  );

  // decoded levels used by all groups
  assign running = (state == hpps_pkg::HPPS_RUN);
  assign supply = sync_bus.stable[hpps_pkg::SB_SUPPLY];
  // low level on the sense pin means over-current
  assign oc_active = ~sync_bus.stable[hpps_pkg::SB_OCL]; // R15 R12
  assign internal_mode = (cfg == hpps_pkg::CFG_INTERNAL); // R13

  // strap meaning only holds in internal default mode
  always_comb
  begin
    nonrem = 2'h0;
    led_act_low = 2'h3; // R03
    if (internal_mode)
    begin
      led_act_low = fixed; // R05 R06 R07 R08
      unique case (fixed)
        2'h0: nonrem = 2'h0; // R05
        2'h1: nonrem = 2'h1; // R06
        2'h2: nonrem = 2'h3; // R07
        2'h3: nonrem = 2'h3; // R08
      endcase
    end
  end

  // strap capture: wait for synchroniser, then latch once
  always_comb
  begin
    next_state = state;
    next_settle = settle;
    next_pol = pol;
    next_fixed = fixed;
    next_cfg = cfg;
    unique case (state)
      hpps_pkg::HPPS_SETTLE:
      begin
        if (settle == hpps_pkg::SETTLE_CYC)
        begin
          // take every strap in the same cycle
          next_pol = sync_bus.stable[hpps_pkg::SB_POL]; // R10
          next_fixed = sync_bus.stable[hpps_pkg::SB_FIX +: 2]; // R04
          next_cfg = {sync_bus.stable[hpps_pkg::SB_CFGHI], sync_bus.stable[hpps_pkg::SB_CFGLO]};
          next_state = hpps_pkg::HPPS_RUN;
        end
        else
        begin
          next_settle = settle + 3'h1;
        end
      end
      hpps_pkg::HPPS_RUN:
      begin
        // latched values hold until the next reset
        next_state = hpps_pkg::HPPS_RUN; // R10
      end
      default:
      begin
        // illegal code restarts the capture
        next_state = hpps_pkg::HPPS_SETTLE;
        next_settle = 3'h0;
      end
    endcase
  end

  // strap capture registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= hpps_pkg::HPPS_SETTLE;
      settle <= 3'h0;
      pol <= 1'b0;
      fixed <= 2'h0;
      cfg <= 2'h0;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
      pol <= next_pol;
      fixed <= next_fixed;
      cfg <= next_cfg;
    end
  end

  // apb decode
  assign hit_ctrl = (paddr == hpps_pkg::CTRL_ADDR);
  assign hit_stat = (paddr == hpps_pkg::STAT_ADDR);
  assign hit_evt = (paddr == hpps_pkg::EVT_ADDR);
  // write takes effect on the edge that samples pready high
  assign bus_wr = psel & penable & pready & pwrite;

  // status word from live block state
  always_comb
  begin
    stat_word = 32'h0;
    stat_word[hpps_pkg::S_SUPPLY] = supply;
    stat_word[hpps_pkg::S_OC] = oc_active;
    stat_word[hpps_pkg::S_POL] = pol;
    stat_word[hpps_pkg::S_FIXED +: 2] = fixed;
    stat_word[hpps_pkg::S_NONREM +: 2] = nonrem;
    stat_word[hpps_pkg::S_CFG +: 2] = cfg;
    stat_word[hpps_pkg::S_INTERNAL] = internal_mode;
    stat_word[hpps_pkg::S_CAPTURED] = running;
  end

  // sticky events from synchronised edges
  always_comb
  begin
    evt_set = hpps_pkg::EVT_RESET;
    evt_set[hpps_pkg::E_OC] = oc_active & ~oc_prev; // R12
    evt_set[hpps_pkg::E_SUP_LOST] = ~supply & sup_prev;
    evt_set[hpps_pkg::E_SUP_SEEN] = supply & ~sup_prev;
    evt_clr = hpps_pkg::EVT_RESET;
    if (bus_wr && hit_evt)
    begin
      evt_clr = pwdata[hpps_pkg::EVT_W-1:0];
    end
  end

  // register file and bus answer
  always_comb
  begin
    next_ctrl = ctrl;
    // a new event beats a clear in the same cycle
    next_evt = (evt & ~evt_clr) | evt_set;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_pready = 1'b0;
    if (bus_wr && hit_ctrl)
    begin
      next_ctrl = pwdata[hpps_pkg::CTRL_W-1:0];
    end
    if (psel && !penable)
    begin
      // setup cycle: answer ready in the first access cycle
      next_pready = 1'b1;
      next_pslverr = ~(hit_ctrl | hit_stat | hit_evt);
      next_prdata = 32'h0;
      if (!pwrite)
      begin
        if (hit_ctrl)
        begin
          next_prdata[hpps_pkg::CTRL_W-1:0] = ctrl;
        end
        else if (hit_stat)
        begin
          next_prdata = stat_word;
        end
        else if (hit_evt)
        begin
          next_prdata[hpps_pkg::EVT_W-1:0] = evt;
        end
      end
    end
  end

  // register file and bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= hpps_pkg::CTRL_RESET;
      evt <= hpps_pkg::EVT_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      evt <= next_evt;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // software led request per port
  assign led_on = {ctrl[hpps_pkg::C_LED2_ON], ctrl[hpps_pkg::C_LED1_ON]};
  assign led_enabled = internal_mode | ctrl[hpps_pkg::C_LED_CFG_EN]; // R03
  // power off until requested; an unserved over-current keeps it off
  assign power_on = ctrl[hpps_pkg::C_PWR_REQ] & ~evt[hpps_pkg::E_OC] & ~oc_active; // R16

  // pin output values
  always_comb
  begin
    // asserted level equals the latched polarity
    next_ppe = power_on ? next_pol : ~next_pol; // R02 R11 R16
    next_led_out = 2'h0;
    next_led_oe = 2'h0;
    if (next_state == hpps_pkg::HPPS_RUN && led_enabled)
    begin
      // strap pins are released to leds once captured
      next_led_out = led_on ^ led_act_low; // R03 R05 R06 R07 R08
      next_led_oe = 2'h3;
    end
    // attach pull-up only with upstream supply present
    next_pullup = running & supply & ctrl[hpps_pkg::C_ATTACH_EN]; // R01
  end

  // pin output registers and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ppe <= 1'b0;
      port_indicator_led_out <= 2'h0;
      port_indicator_led_oe <= 2'h0;
      upstream_pullup_enable <= 1'b0;
      oc_prev <= 1'b0;
      sup_prev <= 1'b0;
    end
    else
    begin
      ppe <= next_ppe;
      port_indicator_led_out <= next_led_out;
      port_indicator_led_oe <= next_led_oe;
      upstream_pullup_enable <= next_pullup;
      oc_prev <= oc_active;
      sup_prev <= supply;
    end
  end

  // in reset and until capture the live strap sets the idle level
  always_comb
  begin
    if (!presetn || !running)
    begin
      port_power_enable = ~power_polarity_strap; // R09 R11
    end
    else
    begin
      port_power_enable = ppe; // R02 R10
    end
  end

endmodule
`default_nettype wire

/* File: shared/hpps_pkg.sv */
// package: constants and types of the hub port power and strap block
package hpps_pkg;

  // apb register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] EVT_ADDR = 8'h08;

  // control register fields and reset value
  localparam int CTRL_W = 5;
  localparam int C_PWR_REQ = 0;
  localparam int C_ATTACH_EN = 1;
  localparam int C_LED_CFG_EN = 2;
  localparam int C_LED1_ON = 3;
  localparam int C_LED2_ON = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h02;

  // status register fields
  localparam int S_SUPPLY = 0;
  localparam int S_OC = 1;
  localparam int S_POL = 2;
  localparam int S_FIXED = 3;
  localparam int S_NONREM = 5;
  localparam int S_CFG = 7;
  localparam int S_INTERNAL = 9;
  localparam int S_CAPTURED = 10;

  // event register fields (write one to clear)
  localparam int EVT_W = 3;
  localparam int E_OC = 0;
  localparam int E_SUP_LOST = 1;
  localparam int E_SUP_SEEN = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

  // synchroniser bus bit positions
  localparam int SYNC_W = 7;
  localparam int SB_SUPPLY = 0;
  localparam int SB_OCL = 1;
  localparam int SB_POL = 2;
  localparam int SB_FIX = 3;
  localparam int SB_CFGLO = 5;
  localparam int SB_CFGHI = 6;
  // idle levels of the synchronised pins
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h02;

  // config select code {hi, lo} for internal default configuration
  localparam logic [1:0] CFG_INTERNAL = 2'h2;

  // edges after reset release before straps are taken
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  // least reset pulse held by the system, and its cycle count
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // block phase after reset
  typedef enum logic [1:0] {
    HPPS_SETTLE = 2'b01,
    HPPS_RUN = 2'b10
  } hpps_state_t;

endpackage

/* File: shared/hpps_sync_if.sv */
// interface: raw pin levels in, filtered synchronised levels out
`timescale 1ns/10ps
`default_nettype none
interface hpps_sync_if;
  logic [hpps_pkg::SYNC_W-1:0] raw; // levels straight from the pins
  logic [hpps_pkg::SYNC_W-1:0] stable; // levels after three flops
  modport user (output raw, input stable);
  modport sync (input raw, output stable);
endinterface
`default_nettype wire

/* File: rtl/hpps_sync.sv */
// module: three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module hpps_sync (
  input wire logic pclk,
  input wire logic presetn,
  hpps_sync_if.sync bus
);
  // three flop stages and the accepted value
  logic [hpps_pkg::SYNC_W-1:0] s1;
  logic [hpps_pkg::SYNC_W-1:0] s2;
  logic [hpps_pkg::SYNC_W-1:0] s3;
  logic [hpps_pkg::SYNC_W-1:0] next_stable;

  // a bit changes only once stage two and three agree
  always_comb
  begin
    next_stable = (s2 & s3) | (bus.stable & (s2 ^ s3));
  end

  // stage one feeds stage two and nothing else
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= hpps_pkg::SYNC_RESET;
      s2 <= hpps_pkg::SYNC_RESET;
      s3 <= hpps_pkg::SYNC_RESET;
      bus.stable <= hpps_pkg::SYNC_RESET;
    end
    else
    begin
      s1 <= bus.raw;
      s2 <= s1;
      s3 <= s2;
      bus.stable <= next_stable;
    end
  end
endmodule
`default_nettype wire

/* File: verif/hpps_top_monitor.sv */
// checker: timing relations at the port power block pins
`timescale 1ns/10ps
`default_nettype none
module hpps_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic upstream_supply_sense,
  input wire logic overcurrent_sense_low,
  input wire logic power_polarity_strap,
  input wire logic port_power_enable,
  input wire logic upstream_pullup_enable
);
  logic [2:0] run_cnt; // edges since release, saturating
  logic pol_q; // polarity seen just after release
  logic req_seen; // power requested since release
  logic pwr_wr; // completed control write asking for power
  logic [2:0] next_run_cnt;
  logic next_pol_q;
  logic next_req_seen;
  assign pwr_wr = psel && penable && pready && pwrite && paddr == hpps_pkg::CTRL_ADDR && pwdata[0];
  // next values of helper state
  always_comb
  begin
    next_run_cnt = (run_cnt == 3'h7) ? run_cnt : run_cnt + 3'h1;
    next_pol_q = (run_cnt == 3'h0) ? power_polarity_strap : pol_q;
    next_req_seen = req_seen || pwr_wr;
  end
  // helper state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_cnt <= 3'h0;
      pol_q <= 1'h0;
      req_seen <= 1'h0;
    end
    else
    begin
      run_cnt <= next_run_cnt;
      pol_q <= next_pol_q;
      req_seen <= next_req_seen;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pre_capture: assert property (run_cnt < 3'h4 |-> port_power_enable == !power_polarity_strap)
    else $error("power enable not idle before capture");
  a_pullup_supply: assert property (!upstream_supply_sense [*8] |-> !upstream_pullup_enable)
    else $error("pullup without upstream supply");
  a_pol_kept: assert property ((run_cnt == 3'h7 && !(psel && pwrite) && overcurrent_sense_low) [*8]
    |-> $stable(port_power_enable))
    else $error("power enable moved without cause");
  a_power_idle: assert property (run_cnt == 3'h7 && !req_seen |-> port_power_enable == !pol_q)
    else $error("power on without request");
  a_power_on: assert property ((overcurrent_sense_low [*8] ##0 pwr_wr) |-> ##2 port_power_enable == pol_q)
    else $error("power not on after request");
  a_oc_cut: assert property (!overcurrent_sense_low [*7] |-> port_power_enable == !pol_q)
    else $error("power kept during over-current");
  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single access cycle");
  a_bad_addr: assert property (psel && !penable && paddr > hpps_pkg::EVT_ADDR |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule
bind hpps_top hpps_top_monitor uut_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .upstream_supply_sense(upstream_supply_sense), .overcurrent_sense_low(overcurrent_sense_low),
  .power_polarity_strap(power_polarity_strap), .port_power_enable(port_power_enable),
  .upstream_pullup_enable(upstream_pullup_enable));
`default_nettype wire

/* File: verif/hpps_partner.sv */
// partner: power switch fault flag and led strap resistors
`timescale 1ns/10ps
`default_nettype none
module hpps_partner (
  input wire logic short_fault,
  input wire logic [1:0] strap,
  input wire logic [1:0] led_out,
  input wire logic [1:0] led_oe,
  output logic overcurrent_sense_low,
  output logic [1:0] led_pin
);
  // switch pulls its flag low while the port is shorted
  assign overcurrent_sense_low = !short_fault;
  // strap resistor sets the pin unless the hub drives it
  assign led_pin = (led_oe & led_out) | (~led_oe & strap);
endmodule
`default_nettype wire

/* File: verif/hpps_top_bench.sv */
// testbench: strap, power and led checks over apb
`timescale 1ns/10ps
`default_nettype none
module hpps_top_bench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sup = 1'h0;
  logic ocl;
  logic pol = 1'h0;
  logic cfg_lo = 1'h0;
  logic cfg_hi = 1'h1;
  logic [1:0] led_in;
  logic [1:0] led_out;
  logic [1:0] led_oe;
  logic ppe;
  logic pull;
  logic fault = 1'h0;
  logic [1:0] strap = 2'h0;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  hpps_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upstream_supply_sense(sup), .overcurrent_sense_low(ocl), .power_polarity_strap(pol),
    .config_select_lo(cfg_lo), .config_select_hi(cfg_hi), .port_indicator_led_in(led_in),
    .port_indicator_led_out(led_out), .port_indicator_led_oe(led_oe), .port_power_enable(ppe),
    .upstream_pullup_enable(pull));
  hpps_partner sw (.short_fault(fault), .strap(strap), .led_out(led_out), .led_oe(led_oe),
    .overcurrent_sense_low(ocl), .led_pin(led_in));
  // free running clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  // run summary and verdict
  task wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // compare one value
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until ready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    rdy = 1'h0;
    // request stands until the rising edge that samples pready high
    while (!rdy)
    begin
      @(posedge pclk);
      rdy = (pready === 1'h1);
    end
    // answer taken at that same edge
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // reset with given straps, held the least documented time
  task boot(input logic p, input logic [1:0] s, input logic lo);
    presetn <= 1'h0;
    pol <= p;
    strap <= s;
    cfg_lo <= lo;
    sup <= 1'h0;
    repeat (hpps_pkg::RESET_MIN_CYC) @(posedge pclk);
    check("power in reset", 32'(ppe), 32'(!p));
    presetn <= 1'h1;
    repeat (10) @(posedge pclk);
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      wrap_up;
    end
  end
  // four strap codes in strap mode, then loaded configuration
  initial
  begin
    logic [1:0] s;
    logic p;
    logic in;
    logic [1:0] nr;
    for (int i = 0; i < 5; i++)
    begin
      s = (i < 4) ? i[1:0] : 2'h0;
      p = i[0];
      in = (i < 4);
      nr = !in || s == 2'h0 ? 2'h0 : (s == 2'h1 ? 2'h1 : 2'h3);
      boot(p, s, !in);
      apb(1'h0, hpps_pkg::STAT_ADDR, 32'h0);
      check("status", rd, {21'h0, 1'h1, in, 1'h1, !in, nr, s, p, 2'h0});
      check("pullup idle", 32'(pull), 32'h0);
      sup <= 1'h1;
      repeat (8) @(posedge pclk);
      check("pullup", 32'(pull), 32'h1);
      apb(1'h1, hpps_pkg::CTRL_ADDR, in ? 32'h0A : 32'h0E);
      repeat (2) @(posedge pclk);
      check("led out", 32'(led_out), 32'(2'h1 ^ (in ? s : 2'h3)));
      check("led oe", 32'(led_oe), 32'h3);
      check("power idle", 32'(ppe), 32'(!p));
      apb(1'h1, hpps_pkg::CTRL_ADDR, 32'h03);
      repeat (2) @(posedge pclk);
      check("power on", 32'(ppe), 32'(p));
      pol <= !p;
      repeat (10) @(posedge pclk);
      check("polarity kept", 32'(ppe), 32'(p));
      fault <= 1'h1;
      repeat (8) @(posedge pclk);
      check("power cut", 32'(ppe), 32'(!p));
      fault <= 1'h0;
      repeat (8) @(posedge pclk);
      check("power held off", 32'(ppe), 32'(!p));
      apb(1'h0, hpps_pkg::EVT_ADDR, 32'h0);
      check("oc event", rd & 32'h1, 32'h1);
      apb(1'h1, hpps_pkg::EVT_ADDR, 32'h1);
      apb(1'h1, hpps_pkg::CTRL_ADDR, 32'h03);
      repeat (2) @(posedge pclk);
      check("power back", 32'(ppe), 32'(p));
    end
    apb(1'h0, 8'h0C, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
